// ### verification/tb.sv
// Testbench: decoder with datapath model and register bus master
`timescale 1ns/1ps
module tb;
   logic               clk;
   logic               rst_b;
   logic               instr_valid;
   logic [11:0]        instr;
   logic [7:0]         file_rdata;
   tid_pkg::tid_pins_t pin_levels;
   tid_pkg::tid_ctl_t  ctl_q;
   logic [7:0]         w_q, status_q, option_q, tristate_load_op_q;
   logic [2:0]         bank_q;
   logic [3:0]         avs_address, avs_byteenable;
   logic               avs_read, avs_write, avs_waitrequest;
   logic [31:0]        avs_writedata, avs_readdata, rd;
   int                 error_cnt, tests_run;
   logic [11:0]        lit_c [5] = '{12'hC5A, 12'hE0F, 12'hF0A, 12'hD81, 12'h040};
   logic [15:0]        lit_e [5] = '{16'h185A, 16'h180A, 16'h1C00, 16'h1881, 16'h1C00};

   tid_decoder i_tid_decoder (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
      .instr(instr), .file_rdata(file_rdata), .pin_levels(pin_levels), .ctl_q(ctl_q),
      .w_q(w_q), .status_q(status_q), .bank_q(bank_q), .option_q(option_q), .tristate_load_op_q(tristate_load_op_q),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   tid_dp_model i_tid_dp_model (.clk(clk), .ctl(ctl_q), .addr(instr[4:0]), .rdata(file_rdata));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One word, then an idle cycle; outputs read in the cycle the pulse stands
   task automatic run(input logic [11:0] w);
      @(posedge clk);
      instr <= w;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Values read here are those sampled at this edge; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic t_reset;
      bus(1'b0, tid_pkg::REG_CORE, 32'h0);
      chk("core", rd, 32'h0000_1800);
      bus(1'b0, tid_pkg::REG_PCFG, 32'h0);
      chk("pcfg", rd, 32'h0000_FFFF);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", rd, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_literal;
      for (int i = 0; i < 5; i++) begin
         run(lit_c[i]);
         chk("st_w", {status_q, w_q}, lit_e[i]);
      end
      $display("test literal done");
   endtask
   task automatic t_add;
      run(12'hCC1);
      run(12'h1C9);
      chk("add_w", {status_q, w_q}, 16'h1B10);
      run(12'h1E9);
      chk("add_f", {ctl_q.file_we, ctl_q.file_addr, ctl_q.file_wdata}, {1'b1, 5'd9, 8'h5F});
      chk("add_st_w", {status_q, w_q}, 16'h1810);
      $display("test add done");
   endtask
   task automatic t_skip;
      run(12'h709);
      chk("test_set", {ctl_q.flush_next, status_q}, 9'h118);
      run(12'h000);
      run(12'h609);
      chk("test_clr", ctl_q.flush_next, 1'b0);
      run(12'h3DF);
      chk("incsz", {ctl_q.flush_next, status_q, w_q}, 17'h11800);
      run(12'h000);
      $display("test skip done");
   endtask
   task automatic t_branch;
      @(posedge clk);
      instr <= 12'hB12;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr <= 12'hC77;
      #1;
      chk("jump", {ctl_q.pc_load, ctl_q.flush_next, ctl_q.pc_target}, {2'b11, 11'h112});
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      chk("drop", {ctl_q.pc_load, w_q}, 9'h000);
      run(12'h934);
      chk("call", {ctl_q.stack_push, ctl_q.pc_load, ctl_q.pc_target}, {2'b11, 11'h034});
      run(12'h000);
      run(12'h8AB);
      chk("ret", {ctl_q.stack_pop, ctl_q.pc_from_stack, w_q}, {2'b11, 8'hAB});
      run(12'h000);
      $display("test branch done");
   endtask
   task automatic t_ctrl;
      run(12'h006);
      chk("tristate_load_op", tristate_load_op_q, 8'hAB);
      run(12'h015);
      chk("bank", bank_q, 3'h5);
      run(12'h003);
      chk("sleep", {ctl_q.sleep, status_q[4:3]}, 3'b110);
      run(12'h004);
      chk("wdt", {ctl_q.wdt_clr, status_q[4:3]}, 3'b111);
      run(12'h225);
      chk("pins", ctl_q.file_wdata, 8'h96);
      run(12'hC00);
      run(12'h002);
      chk("option", option_q, 8'h00);
      run(12'h061);
      chk("presc", ctl_q.presc_clr, 1'b1);
      bus(1'b1, tid_pkg::REG_CTRL, 32'h0);
      run(12'hC33);
      chk("off", w_q, 8'h00);
      bus(1'b0, tid_pkg::REG_CTRL, 32'h0);
      chk("ctrl", rd, 32'h0);
      // A control write without its low byte lane must be ignored
      avs_byteenable <= 4'hE;
      bus(1'b1, tid_pkg::REG_CTRL, 32'h1);
      avs_byteenable <= 4'hF;
      bus(1'b0, tid_pkg::REG_CTRL, 32'h0);
      chk("ctrl_be", rd, 32'h0);
      bus(1'b1, tid_pkg::REG_CTRL, 32'h1);
      run(12'hC33);
      chk("on", w_q, 8'h33);
      $display("test control done");
   endtask
   initial begin
      error_cnt = 0;
      tests_run = 0;
      rst_b = 1'b0;
      instr_valid = 1'b0;
      instr = 12'h000;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      pin_levels = 24'hA53C96;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_literal;
      t_add;
      t_skip;
      t_branch;
      t_ctrl;
      give_verdict;
   end
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      give_verdict;
   end
endmodule

// ### verification/tid_dec_props.sv
// Checker: port-level properties of the instruction decoder
`timescale 1ns/1ps
module tid_dec_props (
   input wire logic          clk,
   input wire logic          rst_b,
   input wire logic          instr_valid,
   input wire logic [11:0]   instr,
   input wire logic [7:0]    file_rdata,
   input tid_pkg::tid_pins_t pin_levels,
   input tid_pkg::tid_ctl_t  ctl_q,
   input wire logic [7:0]    w_q,
   input wire logic [7:0]    status_q,
   input wire logic [2:0]    bank_q,
   input wire logic [7:0]    option_q,
   input wire logic [7:0]    tristate_load_op_q,
   input wire logic [3:0]    avs_address,
   input wire logic          avs_read,
   input wire logic          avs_write,
   input wire logic [31:0]   avs_writedata,
   input wire logic [3:0]    avs_byteenable,
   input wire logic [31:0]   avs_readdata,
   input wire logic          avs_waitrequest
);
   logic en_q;
   logic ex;
   logic hold_q;
   logic pend;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         en_q <= tid_pkg::RST_ENABLE;
      end else if (avs_write && !avs_waitrequest && avs_address == tid_pkg::REG_CTRL
                   && avs_byteenable[0]) begin
         en_q <= avs_writedata[0];
      end
   end
   // The dropped word may come cycles after the branch, so the flush is held
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= pend && !instr_valid;
      end
   end
   assign pend = ctl_q.flush_next || hold_q;
   // A word shadowed by a branch must not be judged as executed
   assign ex = instr_valid && en_q && !pend;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");
   AST_ADD_W: assert property (
      ex && instr[11:5] == 7'b0001110 && instr[4:3] != 2'b00
      |=> {status_q[0], w_q} == {1'b0, $past(w_q)} + {1'b0, $past(file_rdata)})
      else $error("add result or carry wrong");
   AST_AND_LIT: assert property (
      ex && instr[11:8] == 4'hE
      |=> w_q == ($past(w_q) & $past(instr[7:0])) && status_q[2] == (w_q == 8'h00))
      else $error("and literal wrong");
   AST_TEST_STABLE: assert property (
      ctl_q.flush_next && $past(instr[11:10]) == 2'b01 && $past(instr[9]) |-> $stable(status_q))
      else $error("bit test changed status");
   AST_JUMP_BIT8: assert property (
      ctl_q.pc_load && ctl_q.pc_target[8] |-> $past(instr[11:9]) == 3'b101)
      else $error("counter bit 8 set by non-jump");
   AST_CALL: assert property (
      ex && instr[11:8] == 4'h9 |=> ctl_q.stack_push && ctl_q.pc_load
      && ctl_q.pc_target == {status_q[6:5], 1'b0, $past(instr[7:0])})
      else $error("call target wrong");
   AST_TRISTATE_LOAD_OP: assert property (ex && instr == 12'h006 |=> tristate_load_op_q == $past(w_q))
      else $error("tristate latch not loaded");
   AST_SLEEP: assert property (
      ex && instr == tid_pkg::OPC_SLEEP |=> status_q[4:3] == 2'b10 && ctl_q.sleep)
      else $error("standby flags wrong");
   AST_BANK: assert property (ex && instr[11:3] == 9'h002 |=> bank_q == $past(instr[2:0]))
      else $error("bank select wrong");
endmodule
bind tid_decoder tid_dec_props i_tid_dec_props (.*);

// ### verification/tid_dp_model.sv
// Datapath model: file registers read by address, written by decoder controls
`timescale 1ns/1ps
module tid_dp_model (
   input wire logic          clk,
   input tid_pkg::tid_ctl_t  ctl,
   input wire logic [4:0]    addr,
   output logic [7:0]        rdata
);
   logic [7:0] mem_q [32];
   initial begin
      for (int i = 0; i < 32; i++) begin
         mem_q[i] = {i[4:0], 3'h7};
      end
   end
   always @(posedge clk) begin
      if (ctl.file_we) begin
         mem_q[ctl.file_addr] <= ctl.file_wdata;
      end
   end
   assign rdata = mem_q[addr];
endmodule

// ### verilog/tid_alu.sv
// Arithmetic and logic unit for the decoder's byte and bit operations
`timescale 1ns/1ps
module tid_alu (
   input  tid_pkg::tid_alu_op_t op,
   input  wire logic [7:0]      w_val,
   input  wire logic [7:0]      f_val,
   input  wire logic [2:0]      bit_sel,
   input  wire logic            carry_in,
   output logic [7:0]           result,
   output logic                 carry_out,
   output logic                 dcarry_out
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] mask;

   always_comb begin
      mask = 8'h01 << bit_sel;
      sum = 9'h000;
      nib = 5'h00;
      result = f_val;
      carry_out = carry_in;
      dcarry_out = 1'b0;
      unique case (op)
         tid_pkg::ALU_PASS_F: result = f_val;
         tid_pkg::ALU_PASS_W: result = w_val;
         tid_pkg::ALU_ADD: begin
            sum = {1'b0, f_val} + {1'b0, w_val};
            nib = {1'b0, f_val[3:0]} + {1'b0, w_val[3:0]};
            result = sum[7:0];
            carry_out = sum[8];
            dcarry_out = nib[4];
         end
         tid_pkg::ALU_SUB: begin
            // Carry set means no borrow
            sum = {1'b0, f_val} + {1'b0, ~w_val} + 9'h001;
            nib = {1'b0, f_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
            result = sum[7:0];
            carry_out = sum[8];
            dcarry_out = nib[4];
         end
         tid_pkg::ALU_AND:  result = w_val & f_val;
         tid_pkg::ALU_OR:   result = w_val | f_val;
         tid_pkg::ALU_XOR:  result = w_val ^ f_val;
         tid_pkg::ALU_COM:  result = ~f_val;
         tid_pkg::ALU_INC:  result = f_val + 8'h01;
         tid_pkg::ALU_DEC:  result = f_val - 8'h01;
         tid_pkg::ALU_RLC: begin
            result = {f_val[6:0], carry_in};
            carry_out = f_val[7];
         end
         tid_pkg::ALU_RRC: begin
            result = {carry_in, f_val[7:1]};
            carry_out = f_val[0];
         end
         tid_pkg::ALU_SWAP: result = {f_val[3:0], f_val[7:4]};
         tid_pkg::ALU_CLR:  result = 8'h00;
         tid_pkg::ALU_BCLR: result = f_val & ~mask;
         tid_pkg::ALU_BSET: result = f_val | mask;
      endcase
   end
endmodule

// ### verilog/tid_decoder.sv
// Twelve-bit instruction decoder and executer with Avalon control port
`timescale 1ns/1ps
module tid_decoder (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              instr_valid,
   input  wire logic [11:0]       instr,
   input  wire logic [7:0]        file_rdata,
   input  tid_pkg::tid_pins_t     pin_levels,
   output tid_pkg::tid_ctl_t      ctl_q,
   output logic [7:0]             w_q,
   output logic [7:0]             status_q,
   output logic [2:0]             bank_q,
   output logic [7:0]             option_q,
   output logic [7:0]             tristate_load_op_q,
   input  wire logic [3:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest
);
   tid_pkg::tid_alu_op_t op;
   tid_pkg::tid_skip_t   skip_kind;
   logic       use_lit;
   logic       to_w;
   logic       to_file;
   logic       upd_c;
   logic       upd_dc;
   logic       upd_z;
   logic       is_jump;
   logic       is_call;
   logic       is_ret;
   logic       is_retlit;
   logic       is_bank;
   logic       is_option;
   logic       is_tristate_load_op;
   logic       is_sleep;
   logic       is_wdtclr;
   logic       enable_q;
   logic       flush_q;
   logic       exec;
   logic [4:0] faddr;
   logic [7:0] f_eff;
   logic [7:0] alu_b;
   logic [7:0] res;
   logic       c_out;
   logic       dc_out;
   logic       res_zero;
   logic       skip_now;
   logic       pcl_write;
   logic       pc_change;
   logic [1:0] page;

   assign faddr = instr[4:0];
   assign page = status_q[tid_pkg::ST_PA_HI:tid_pkg::ST_PA_LO];
   // A word fetched behind a branch or taken skip is dropped as a no-op
   assign exec = instr_valid && enable_q && !flush_q;

   // Operand source; ports give pin levels, not latches
   always_comb begin
      if (faddr == tid_pkg::FA_STATUS) begin
         f_eff = status_q;
      end else if (tid_pkg::tid_is_port(faddr)) begin
         unique case (faddr)
            tid_pkg::FA_PORT_LO: f_eff = pin_levels.port5;
            tid_pkg::FA_PORT_HI: f_eff = pin_levels.port7;
            default:             f_eff = pin_levels.port6;
         endcase
      end else begin
         f_eff = file_rdata;
      end
   end

   always_comb begin
      op = tid_pkg::ALU_PASS_F;
      skip_kind = tid_pkg::SKIP_NONE;
      use_lit = 1'b0;
      to_w = 1'b0;
      to_file = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b0;
      is_jump = 1'b0;
      is_call = 1'b0;
      is_ret = 1'b0;
      is_retlit = 1'b0;
      is_bank = 1'b0;
      is_option = 1'b0;
      is_tristate_load_op = 1'b0;
      is_sleep = 1'b0;
      is_wdtclr = 1'b0;
      casez (instr)
         tid_pkg::OPC_NOP:    ;
         tid_pkg::OPC_OPTION: is_option = 1'b1;
         tid_pkg::OPC_SLEEP:  is_sleep = 1'b1;
         tid_pkg::OPC_WDTCLR: is_wdtclr = 1'b1;
         tid_pkg::OPC_TRISTATE_LOAD_OP:   is_tristate_load_op = 1'b1;
         tid_pkg::OPC_BANK:   is_bank = 1'b1;
         tid_pkg::OPC_RET,
         tid_pkg::OPC_RETI:   is_ret = 1'b1;
         tid_pkg::OPC_MOVE_WORK_TO_FILE: begin
            op = tid_pkg::ALU_PASS_W;
            to_file = 1'b1;
         end
         tid_pkg::OPC_CLEAR_WORK: begin
            op = tid_pkg::ALU_CLR;
            to_w = 1'b1;
            upd_z = 1'b1;
         end
         tid_pkg::OPC_CLEAR_FILE: begin
            op = tid_pkg::ALU_CLR;
            to_file = 1'b1;
            upd_z = 1'b1;
         end
         tid_pkg::OPC_BCLR: begin
            op = tid_pkg::ALU_BCLR;
            to_file = 1'b1;
         end
         tid_pkg::OPC_BSET: begin
            op = tid_pkg::ALU_BSET;
            to_file = 1'b1;
         end
         tid_pkg::OPC_BTSC:   skip_kind = tid_pkg::SKIP_BCLR;
         tid_pkg::OPC_BTSS:   skip_kind = tid_pkg::SKIP_BSET;
         tid_pkg::OPC_RETLIT: begin
            is_retlit = 1'b1;
            use_lit = 1'b1;
            to_w = 1'b1;
         end
         tid_pkg::OPC_CALL:   is_call = 1'b1;
         tid_pkg::OPC_JUMP:   is_jump = 1'b1;
         tid_pkg::OPC_MOVL: begin
            use_lit = 1'b1;
            to_w = 1'b1;
         end
         tid_pkg::OPC_IORL,
         tid_pkg::OPC_ANDL,
         tid_pkg::OPC_XORL: begin
            op = (instr[9:8] == 2'b01) ? tid_pkg::ALU_OR :
                 (instr[9:8] == 2'b10) ? tid_pkg::ALU_AND : tid_pkg::ALU_XOR;
            use_lit = 1'b1;
            to_w = 1'b1;
            upd_z = 1'b1;
         end
         default: begin
            // Byte operations 0000 10.. through 0011 11..
            to_w = !instr[5];
            to_file = instr[5];
            upd_z = 1'b1;
            casez (instr)
               tid_pkg::OPC_SUB: begin
                  op = tid_pkg::ALU_SUB;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
               end
               tid_pkg::OPC_DEC: op = tid_pkg::ALU_DEC;
               tid_pkg::OPC_IOR: op = tid_pkg::ALU_OR;
               tid_pkg::OPC_AND: op = tid_pkg::ALU_AND;
               tid_pkg::OPC_XOR: op = tid_pkg::ALU_XOR;
               tid_pkg::OPC_ADD: begin
                  op = tid_pkg::ALU_ADD;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
               end
               tid_pkg::OPC_MOVE_FILE: op = tid_pkg::ALU_PASS_F;
               tid_pkg::OPC_COM:  op = tid_pkg::ALU_COM;
               tid_pkg::OPC_INC:  op = tid_pkg::ALU_INC;
               tid_pkg::OPC_DECSZ,
               tid_pkg::OPC_INCSZ: begin
                  op = instr[8] ? tid_pkg::ALU_INC : tid_pkg::ALU_DEC;
                  skip_kind = tid_pkg::SKIP_ZERO;
                  upd_z = 1'b0;
               end
               tid_pkg::OPC_RRC,
               tid_pkg::OPC_RLC: begin
                  op = instr[6] ? tid_pkg::ALU_RLC : tid_pkg::ALU_RRC;
                  upd_c = 1'b1;
                  upd_z = 1'b0;
               end
               tid_pkg::OPC_SWAP: begin
                  op = tid_pkg::ALU_SWAP;
                  upd_z = 1'b0;
               end
               default: begin
                  to_w = 1'b0;
                  to_file = 1'b0;
                  upd_z = 1'b0;
               end
            endcase
         end
      endcase
   end

   assign alu_b = use_lit ? instr[7:0] : f_eff;

   tid_alu u_alu (
      .op         (op),
      .w_val      (w_q),
      .f_val      (alu_b),
      .bit_sel    (instr[7:5]),
      .carry_in   (status_q[tid_pkg::ST_C]),
      .result     (res),
      .carry_out  (c_out),
      .dcarry_out (dc_out)
   );

   assign res_zero = (res == 8'h00);
   always_comb begin
      unique case (skip_kind)
         tid_pkg::SKIP_ZERO: skip_now = res_zero;
         tid_pkg::SKIP_BCLR: skip_now = !f_eff[instr[7:5]];
         tid_pkg::SKIP_BSET: skip_now = f_eff[instr[7:5]];
         default:            skip_now = 1'b0;
      endcase
   end
   assign pcl_write = to_file && (faddr == tid_pkg::FA_PCL);
   assign pc_change = is_jump || is_call || is_ret || is_retlit || pcl_write;

   // Decoded controls, registered toward datapath and fetch
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctl_q <= '0;
      end else begin
         ctl_q <= '0;
         if (exec) begin
            ctl_q.file_we <= to_file;
            ctl_q.file_addr <= faddr;
            ctl_q.file_wdata <= res;
            ctl_q.pc_load <= is_jump || is_call || pcl_write;
            if (is_jump) begin
               ctl_q.pc_target <= {page, instr[8:0]};
            end else begin
               ctl_q.pc_target <= {page, 1'b0, (is_call ? instr[7:0] : res)};
            end
            ctl_q.stack_push <= is_call;
            ctl_q.pc_from_stack <= is_ret || is_retlit;
            ctl_q.stack_pop <= is_ret || is_retlit;
            ctl_q.flush_next <= pc_change || skip_now;
            ctl_q.presc_clr <= to_file && (faddr == tid_pkg::FA_TIMER)
                               && !option_q[tid_pkg::OPT_PSA];
            ctl_q.wdt_clr <= is_wdtclr;
            ctl_q.sleep <= is_sleep;
         end
      end
   end

   // Second cycle of a branch or taken skip
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         flush_q <= 1'b0;
      end else if (instr_valid && flush_q) begin
         flush_q <= 1'b0;
      end else if (exec) begin
         flush_q <= pc_change || skip_now;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         w_q <= tid_pkg::RST_W;
      end else if (exec && to_w) begin
         w_q <= res;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         status_q <= tid_pkg::RST_STATUS;
      end else if (exec) begin
         // Timeout and powerdown bits are not writable as a file
         if (to_file && faddr == tid_pkg::FA_STATUS) begin
            status_q <= {res[7:5], status_q[4:3], res[2:0]};
         end
         if (upd_c) status_q[tid_pkg::ST_C] <= c_out;
         if (upd_dc) status_q[tid_pkg::ST_DC] <= dc_out;
         if (upd_z) status_q[tid_pkg::ST_Z] <= res_zero;
         if (is_sleep || is_wdtclr) begin
            status_q[tid_pkg::ST_TO] <= 1'b1;
            status_q[tid_pkg::ST_PD] <= is_wdtclr;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bank_q <= tid_pkg::RST_BANK;
      end else if (exec && is_bank) begin
         bank_q <= instr[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         option_q <= tid_pkg::RST_OPTION;
      end else if (exec && is_option) begin
         option_q <= w_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tristate_load_op_q <= tid_pkg::RST_TRISTATE_LOAD_OP;
      end else if (exec && is_tristate_load_op && instr[2:0] == tid_pkg::TRISTATE_LOAD_OP_FIRST_PORT) begin
         tristate_load_op_q <= w_q;
      end
   end

   // Avalon slave: one wait state, then the access completes
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && avs_waitrequest) begin
         unique case (avs_address)
            tid_pkg::REG_CTRL: avs_readdata <= {31'h0000_0000, enable_q};
            tid_pkg::REG_CORE: avs_readdata <= {13'h0000, bank_q, status_q, w_q};
            tid_pkg::REG_PCFG: avs_readdata <= {16'h0000, tristate_load_op_q, option_q};
            default:           avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Decode enable lets software hold the core without stopping fetch
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         enable_q <= tid_pkg::RST_ENABLE;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                   && avs_address == tid_pkg::REG_CTRL) begin
         enable_q <= avs_writedata[0];
      end
   end

endmodule

// ### verilog/tid_pkg.sv
// Package: constants, opcodes and carriers of the instruction decoder
package tid_pkg;

   // Avalon register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CORE = 4'h4;
   localparam logic [3:0] REG_PCFG = 4'h8;

   // Special file addresses
   localparam logic [4:0] FA_TIMER  = 5'h01;
   localparam logic [4:0] FA_PCL    = 5'h02;
   localparam logic [4:0] FA_STATUS = 5'h03;
   localparam logic [4:0] FA_PORT_LO = 5'h05;
   localparam logic [4:0] FA_PORT_HI = 5'h07;
   localparam logic [2:0] TRISTATE_LOAD_OP_FIRST_PORT = 3'h6;

   // Status bit positions
   localparam int ST_C    = 0;
   localparam int ST_DC   = 1;
   localparam int ST_Z    = 2;
   localparam int ST_PD   = 3;
   localparam int ST_TO   = 4;
   localparam int ST_PA_LO = 5;
   localparam int ST_PA_HI = 6;
   // Option bit: 1 = prescaler on watchdog, 0 = on timer
   localparam int OPT_PSA = 3;

   // Reset values
   localparam logic [7:0] RST_W      = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h18;
   localparam logic [2:0] RST_BANK   = 3'h0;
   localparam logic [7:0] RST_OPTION = 8'hFF;
   localparam logic [7:0] RST_TRISTATE_LOAD_OP   = 8'hFF;
   localparam logic       RST_ENABLE = 1'b1;

   // Opcode patterns, ? = operand bit
   localparam logic [11:0] OPC_NOP    = 12'h000;
   localparam logic [11:0] OPC_OPTION = 12'h002;
   localparam logic [11:0] OPC_SLEEP  = 12'h003;
   localparam logic [11:0] OPC_WDTCLR = 12'h004;
   localparam logic [11:0] OPC_TRISTATE_LOAD_OP   = 12'b0000_0000_0???;
   localparam logic [11:0] OPC_BANK   = 12'b0000_0001_0???;
   localparam logic [11:0] OPC_RET    = 12'h01E;
   localparam logic [11:0] OPC_RETI   = 12'h01F;
   localparam logic [11:0] OPC_MOVE_WORK_TO_FILE  = 12'b0000_001?_????;
   localparam logic [11:0] OPC_CLEAR_WORK   = 12'b0000_010?_????;
   localparam logic [11:0] OPC_CLEAR_FILE   = 12'b0000_011?_????;
   localparam logic [11:0] OPC_SUB    = 12'b0000_10??_????;
   localparam logic [11:0] OPC_DEC    = 12'b0000_11??_????;
   localparam logic [11:0] OPC_IOR    = 12'b0001_00??_????;
   localparam logic [11:0] OPC_AND    = 12'b0001_01??_????;
   localparam logic [11:0] OPC_XOR    = 12'b0001_10??_????;
   localparam logic [11:0] OPC_ADD    = 12'b0001_11??_????;
   localparam logic [11:0] OPC_MOVE_FILE   = 12'b0010_00??_????;
   localparam logic [11:0] OPC_COM    = 12'b0010_01??_????;
   localparam logic [11:0] OPC_INC    = 12'b0010_10??_????;
   localparam logic [11:0] OPC_DECSZ  = 12'b0010_11??_????;
   localparam logic [11:0] OPC_RRC    = 12'b0011_00??_????;
   localparam logic [11:0] OPC_RLC    = 12'b0011_01??_????;
   localparam logic [11:0] OPC_SWAP   = 12'b0011_10??_????;
   localparam logic [11:0] OPC_INCSZ  = 12'b0011_11??_????;
   localparam logic [11:0] OPC_BCLR   = 12'b0100_????_????;
   localparam logic [11:0] OPC_BSET   = 12'b0101_????_????;
   localparam logic [11:0] OPC_BTSC   = 12'b0110_????_????;
   localparam logic [11:0] OPC_BTSS   = 12'b0111_????_????;
   localparam logic [11:0] OPC_RETLIT = 12'b1000_????_????;
   localparam logic [11:0] OPC_CALL   = 12'b1001_????_????;
   localparam logic [11:0] OPC_JUMP   = 12'b101?_????_????;
   localparam logic [11:0] OPC_MOVL   = 12'b1100_????_????;
   localparam logic [11:0] OPC_IORL   = 12'b1101_????_????;
   localparam logic [11:0] OPC_ANDL   = 12'b1110_????_????;
   localparam logic [11:0] OPC_XORL   = 12'b1111_????_????;

   typedef enum logic [3:0] {
      ALU_PASS_F, ALU_PASS_W, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR,
      ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_RLC, ALU_RRC,
      ALU_SWAP, ALU_CLR, ALU_BCLR, ALU_BSET
   } tid_alu_op_t;

   typedef enum logic [1:0] {
      SKIP_NONE = 2'h0, SKIP_ZERO = 2'h1, SKIP_BSET = 2'h3, SKIP_BCLR = 2'h2
   } tid_skip_t;

   // Pin levels of the three ports, highest address first (lowest address in the low byte)
   typedef struct packed {
      logic [7:0] port7;
      logic [7:0] port6;
      logic [7:0] port5;
   } tid_pins_t;

   // Controls toward datapath, stack and fetch
   typedef struct packed {
      logic        file_we;
      logic [4:0]  file_addr;
      logic [7:0]  file_wdata;
      logic        pc_load;
      logic [10:0] pc_target;
      logic        pc_from_stack;
      logic        stack_push;
      logic        stack_pop;
      logic        flush_next;
      logic        presc_clr;
      logic        wdt_clr;
      logic        sleep;
   } tid_ctl_t;

   function automatic logic tid_is_port(input logic [4:0] a);
      return (a >= FA_PORT_LO) && (a <= FA_PORT_HI);
   endfunction

endpackage
